//--- hw/imd_top.v
// interrupt redirection unit, local receiver and register slave in one block
//
// Design decisions made here: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
`include "imd_defs.vh"

module imd_top (
  input  wire        clk,
  input  wire        nrst,
  input  wire [8:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output wire [31:0] avs_readdata,
  output wire        avs_waitrequest,
  input  wire [3:0]  io_pin,
  output wire        msg_valid,
  output wire [31:0] msg_addr,
  output wire [31:0] msg_data,
  input  wire        msg_ready,
  input  wire        sys_int_valid,
  input  wire [7:0]  sys_int_dest,
  input  wire [7:0]  sys_int_vector,
  input  wire [2:0]  sys_int_mode,
  input  wire        sys_int_trig,
  input  wire        local_interrupt_pin_a,
  input  wire        local_interrupt_pin_b,
  input  wire        interval_timer_event,
  input  wire        perf_monitor_event,
  input  wire        corrected_machine_check,
  output wire        core_interrupt_request,
  input  wire        core_interrupt_acknowledge,
  output wire [7:0]  core_vector,
  output wire        irq
);

  // highest set bit, flagged by bit 8
  function [8:0] hi_index;
    input [255:0] bits;
    integer k;
    begin
      hi_index = 9'h000;
      for (k = 0; k < `IMD_NVEC; k = k + 1)
        if (bits[k])
          hi_index = {1'b1, k[7:0]};
    end
  endfunction

  function [255:0] onehot;
    input [7:0] v;
    begin
      onehot = 256'h1 << v;
    end
  endfunction

  // byte-enabled write merge
  function [31:0] be_merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  be;
    integer b;
    begin
      be_merge = old;
      for (b = 0; b < 4; b = b + 1)
        if (be[b])
          be_merge[b*8 +: 8] = nw[b*8 +: 8];
    end
  endfunction

  reg [31:0]  redir_entry_reg [0:`IMD_NPINS-1];
  reg [31:0]  local_vector_entry_reg [0:2];
  reg [31:0]  local_pin_redirect_entry_reg [0:1];
  reg [7:0]   local_id_reg;
  reg [3:0]   tpr_reg;
  reg [`IMD_ST_W-1:0] status_reg;
  reg [`IMD_ST_W-1:0] mask_reg;
  reg [255:0] pending_request_bits_reg;
  reg [255:0] in_service_reg;
  reg [3:0]   pin_s1_reg;
  reg [3:0]   pin_s2_reg;
  reg [3:0]   pin_d_reg;
  reg [1:0]   lpin_s1_reg;
  reg [1:0]   lpin_s2_reg;
  reg [1:0]   lpin_d_reg;
  reg [3:0]   armed_reg;
  reg [3:0]   send_reg;
  reg         ipi_busy_reg;
  reg [7:0]   ipi_dest_reg;
  reg [10:0]  ipi_data_reg;
  reg         msg_valid_reg;
  reg [31:0]  msg_addr_reg;
  reg [31:0]  msg_data_reg;
  reg         wait_reg;
  reg [31:0]  rdata_reg;
  reg [31:0]  rdata_next;
  reg         irq_reg;
  reg         core_req_reg;
  reg [7:0]   core_vec_reg;
  reg [3:0]   pin_fire;
  reg [3:0]   pin_take;
  reg [1:0]   lpin_fire;
  reg [255:0] pend_set;
  reg [31:0]  pick_entry;
  reg         pick_ok;
  integer     i, j, m, n;

  assign avs_readdata           = rdata_reg;
  assign avs_waitrequest        = wait_reg;
  assign msg_valid              = msg_valid_reg;
  assign msg_addr               = msg_addr_reg;
  assign msg_data               = msg_data_reg;
  assign core_interrupt_request = core_req_reg;
  assign core_vector            = core_vec_reg;
  assign irq                    = irq_reg;

  // bus handshake: one wait state, block stores stall while a store is queued
  wire req      = avs_read | avs_write;
  wire pib_hit  = avs_address[`IMD_PIB_BIT];
  wire drop     = req & wait_reg & ~(avs_write & pib_hit & ipi_busy_reg);
  wire wr       = avs_write & ~wait_reg;
  wire [3:0] ofs_lo = avs_address[3:0];
  wire hit_lvec = (avs_address >= `IMD_OFS_LVEC) & (avs_address < `IMD_OFS_LPIN);
  wire hit_lpin = (avs_address >= `IMD_OFS_LPIN) & (avs_address < `IMD_OFS_LPIN + 9'h002);
  wire hit_red  = (avs_address >= `IMD_OFS_REDIR) &
                  (avs_address < `IMD_OFS_REDIR + `IMD_NPINS);
  wire hit_pend = (avs_address >= `IMD_OFS_PEND) & (avs_address < `IMD_OFS_LVEC);
  wire [1:0] lvec_idx = ofs_lo[1:0];
  wire       lpin_idx = (avs_address == `IMD_OFS_LPIN) ? 1'b0 : 1'b1;

  // priority resolution: highest pending against tpr class and in-service
  wire [8:0] hp  = hi_index(pending_request_bits_reg);
  wire [8:0] isv = hi_index(in_service_reg);
  wire deliverable = hp[8] & (hp[7:4] > tpr_reg) &
                     (~isv[8] | (hp[7:0] > isv[7:0]));
  wire ivr_read = drop & avs_read & (avs_address == `IMD_OFS_HPV);
  wire take     = deliverable & (core_interrupt_acknowledge | ivr_read);
  wire eos      = wr & (avs_address == `IMD_OFS_EOS) & isv[8];

  // inbound system bus message accepted only on id match and a vector of at least IMD_VEC_MIN
  wire in_acc = sys_int_valid & (sys_int_dest == local_id_reg) &
                (sys_int_vector >= `IMD_VEC_MIN);
  wire [2:0] lev = {corrected_machine_check, perf_monitor_event, interval_timer_event};

  // pin event detection for redirection entries
  always @* begin
    for (i = 0; i < `IMD_NPINS; i = i + 1) begin
      if (redir_entry_reg[i][`IMD_F_MASK])
        pin_fire[i] = 1'b0;
      else if (redir_entry_reg[i][`IMD_F_TRIG])
        pin_fire[i] = pin_s2_reg[i] & armed_reg[i];
      else
        pin_fire[i] = pin_s2_reg[i] & ~pin_d_reg[i];
    end
    for (i = 0; i < 2; i = i + 1) begin
      if (local_pin_redirect_entry_reg[i][`IMD_F_MASK])
        lpin_fire[i] = 1'b0;
      else if (local_pin_redirect_entry_reg[i][`IMD_F_TRIG])
        lpin_fire[i] = lpin_s2_reg[i];
      else
        lpin_fire[i] = lpin_s2_reg[i] & ~lpin_d_reg[i];
    end
  end

  // pending set from every local and accepted source
  always @* begin
    pend_set = 256'h0;
    if (in_acc)
      pend_set = pend_set | onehot(sys_int_vector);
    for (j = 0; j < 3; j = j + 1)
      if (lev[j] & ~local_vector_entry_reg[j][`IMD_F_MASK])
        pend_set = pend_set | onehot(local_vector_entry_reg[j][7:0]);
    for (j = 0; j < 2; j = j + 1)
      if (lpin_fire[j])
        pend_set = pend_set | onehot(local_pin_redirect_entry_reg[j][7:0]);
  end

  // outbound arbitration: store-made message first, then lowest pin
  always @* begin
    pin_take   = 4'h0;
    pick_entry = 32'h0;
    pick_ok    = 1'b0;
    for (m = `IMD_NPINS - 1; m >= 0; m = m - 1)
      if (send_reg[m] & ~ipi_busy_reg) begin
        pin_take   = 4'h1 << m;
        pick_entry = redir_entry_reg[m];
        pick_ok    = 1'b1;
      end
  end

  wire load = ~msg_valid_reg | msg_ready;

  // read data mux, sampled when the wait state drops
  always @* begin
    rdata_next = 32'h0;
    if (avs_address == `IMD_OFS_ID)
      rdata_next = {24'h0, local_id_reg};
    else if (avs_address == `IMD_OFS_TPR)
      rdata_next = {28'h0, tpr_reg};
    else if (avs_address == `IMD_OFS_HPV)
      rdata_next = {24'h0, deliverable ? hp[7:0] : `IMD_SPURIOUS};
    else if (avs_address == `IMD_OFS_STAT)
      rdata_next = {{(32-`IMD_ST_W){1'b0}}, status_reg};
    else if (avs_address == `IMD_OFS_MASK)
      rdata_next = {{(32-`IMD_ST_W){1'b0}}, mask_reg};
    else if (hit_pend)
      rdata_next = pending_request_bits_reg[ofs_lo[2:0]*32 +: 32];
    else if (hit_lvec)
      rdata_next = local_vector_entry_reg[lvec_idx];
    else if (hit_lpin)
      rdata_next = local_pin_redirect_entry_reg[lpin_idx];
    else if (hit_red)
      rdata_next = redir_entry_reg[ofs_lo[1:0]];
  end

  // bus slave and configuration registers
  always @(posedge clk) begin
    if (!nrst) begin
      wait_reg     <= 1'b1;
      rdata_reg    <= 32'h0;
      local_id_reg <= `IMD_ID_RST;
      tpr_reg      <= `IMD_TPR_RST;
      mask_reg     <= {`IMD_ST_W{1'b0}};
      for (n = 0; n < `IMD_NPINS; n = n + 1)
        redir_entry_reg[n] <= `IMD_ENTRY_RST;
      for (n = 0; n < 3; n = n + 1)
        local_vector_entry_reg[n] <= `IMD_ENTRY_RST;
      for (n = 0; n < 2; n = n + 1)
        local_pin_redirect_entry_reg[n] <= `IMD_ENTRY_RST;
    end else begin
      wait_reg <= ~drop;
      if (drop)
        rdata_reg <= avs_read ? rdata_next : 32'h0;
      if (wr & ~pib_hit) begin
        if (avs_address == `IMD_OFS_ID)
          local_id_reg <= avs_byteenable[0] ? avs_writedata[7:0] : local_id_reg;
        if (avs_address == `IMD_OFS_TPR)
          tpr_reg <= avs_byteenable[0] ? avs_writedata[3:0] : tpr_reg;
        if (avs_address == `IMD_OFS_MASK)
          mask_reg <= avs_byteenable[0] ? avs_writedata[`IMD_ST_W-1:0] : mask_reg;
        if (hit_red)
          redir_entry_reg[ofs_lo[1:0]] <= be_merge(redir_entry_reg[ofs_lo[1:0]],
                                                   avs_writedata, avs_byteenable);
        if (hit_lvec)
          local_vector_entry_reg[lvec_idx] <= be_merge(local_vector_entry_reg[lvec_idx],
                                                       avs_writedata, avs_byteenable);
        if (hit_lpin)
          local_pin_redirect_entry_reg[lpin_idx] <=
            be_merge(local_pin_redirect_entry_reg[lpin_idx], avs_writedata,
                     avs_byteenable);
      end
    end
  end

  // pin synchronisers, edge history and level re-arm
  always @(posedge clk) begin
    if (!nrst) begin
      pin_s1_reg  <= 4'h0;
      pin_s2_reg  <= 4'h0;
      pin_d_reg   <= 4'h0;
      lpin_s1_reg <= 2'h0;
      lpin_s2_reg <= 2'h0;
      lpin_d_reg  <= 2'h0;
      armed_reg   <= 4'hf;
      send_reg    <= 4'h0;
    end else begin
      pin_s1_reg  <= io_pin;
      pin_s2_reg  <= pin_s1_reg;
      pin_d_reg   <= pin_s2_reg;
      lpin_s1_reg <= {local_interrupt_pin_b, local_interrupt_pin_a};
      lpin_s2_reg <= lpin_s1_reg;
      lpin_d_reg  <= lpin_s2_reg;
      armed_reg   <= (armed_reg & ~pin_fire) | ~pin_s2_reg;
      send_reg    <= (send_reg & ~(load ? pin_take : 4'h0)) | pin_fire;   // set wins
    end
  end

  // outbound memory-write message stage
  always @(posedge clk) begin
    if (!nrst) begin
      ipi_busy_reg  <= 1'b0;
      ipi_dest_reg  <= 8'h00;
      ipi_data_reg  <= 11'h000;
      msg_valid_reg <= 1'b0;
      msg_addr_reg  <= 32'h0;
      msg_data_reg  <= 32'h0;
    end else begin
      if (wr & pib_hit) begin
        ipi_busy_reg <= 1'b1;
        ipi_dest_reg <= avs_address[7:0];
        ipi_data_reg <= {avs_writedata[`IMD_F_DM_HI:`IMD_F_DM_LO],
                         avs_writedata[`IMD_F_VEC_HI:0]};
      end else if (load & ipi_busy_reg)
        ipi_busy_reg <= 1'b0;
      if (load) begin
        msg_valid_reg <= ipi_busy_reg | pick_ok;
        if (ipi_busy_reg) begin
          msg_addr_reg <= {`IMD_MSG_BASE, ipi_dest_reg, 12'h000};
          msg_data_reg <= {21'h0, ipi_data_reg};
        end else begin
          msg_addr_reg <= {`IMD_MSG_BASE,
                           pick_entry[`IMD_F_DEST_HI:`IMD_F_DEST_LO], 12'h000};
          msg_data_reg <= {16'h0, pick_entry[`IMD_F_TRIG], 4'h0,
                           pick_entry[`IMD_F_DM_HI:0]};
        end
      end
    end
  end

  // pending, in-service, core handshake and event status
  always @(posedge clk) begin
    if (!nrst) begin
      pending_request_bits_reg <= 256'h0;
      in_service_reg           <= 256'h0;
      core_req_reg             <= 1'b0;
      core_vec_reg             <= 8'h00;
      status_reg               <= {`IMD_ST_W{1'b0}};
      irq_reg                  <= 1'b0;
    end else begin
      pending_request_bits_reg <= (pending_request_bits_reg &
                                   ~(take ? onehot(hp[7:0]) : 256'h0)) | pend_set;
      in_service_reg <= (in_service_reg & ~(eos ? onehot(isv[7:0]) : 256'h0)) |
                        (take ? onehot(hp[7:0]) : 256'h0);
      core_req_reg <= deliverable & ~take;
      if (take)
        core_vec_reg <= hp[7:0];
      status_reg <= (status_reg &
                     ~((wr & (avs_address == `IMD_OFS_STAT)) ?
                       avs_writedata[`IMD_ST_W-1:0] : {`IMD_ST_W{1'b0}})) |
                    {|(pend_set & pending_request_bits_reg), in_acc,
                     msg_valid_reg & msg_ready};
      irq_reg <= |(status_reg & mask_reg);
    end
  end

endmodule

//--- hw/imd_defs.vh
// constants for the interrupt message delivery block
`ifndef IMD_DEFS_VH
`define IMD_DEFS_VH

// sizes
`define IMD_NPINS        4
`define IMD_NVEC         256

// register word offsets on the avalon slave
`define IMD_OFS_ID       9'h000
`define IMD_OFS_TPR      9'h001
`define IMD_OFS_HPV      9'h002
`define IMD_OFS_EOS      9'h003
`define IMD_OFS_STAT     9'h004
`define IMD_OFS_MASK     9'h005
`define IMD_OFS_PEND     9'h008
`define IMD_OFS_LVEC     9'h010
`define IMD_OFS_LPIN     9'h013
`define IMD_OFS_REDIR    9'h020
`define IMD_PIB_BIT      8

// entry field positions
`define IMD_F_VEC_HI     7
`define IMD_F_DM_LO      8
`define IMD_F_DM_HI      10
`define IMD_F_TRIG       15
`define IMD_F_MASK       16
`define IMD_F_DEST_LO    24
`define IMD_F_DEST_HI    31

// reset values, spurious vector and lowest accepted vector
`define IMD_ENTRY_RST    32'h0001_0000
`define IMD_ID_RST       8'h00
`define IMD_TPR_RST      4'h0
`define IMD_SPURIOUS     8'h0f
`define IMD_VEC_MIN      8'h10

// outbound message address: base bits above the destination field
`define IMD_MSG_BASE     12'hf00

// status bits
`define IMD_ST_SENT      0
`define IMD_ST_ACC       1
`define IMD_ST_MERGE     2
`define IMD_ST_W         3

`endif

//--- bench/imd_far.sv
// bridge and core model on the far side of the interrupt block
`timescale 1ns/1ps
module imd_far (
  input  wire        clk,
  input  wire        slow,
  input  wire        ack_en,
  input  wire        msg_valid,
  input  wire [31:0] msg_addr,
  input  wire [31:0] msg_data,
  output reg         msg_ready,
  output reg         sys_int_valid,
  output reg  [7:0]  sys_int_dest,
  output reg  [7:0]  sys_int_vector,
  output reg  [2:0]  sys_int_mode,
  output reg         sys_int_trig,
  input  wire        core_interrupt_request,
  output reg         core_interrupt_acknowledge
);
  reg [1:0] cnt;
  // quiet start, lines settle on the first edges
  initial begin
    {msg_ready, sys_int_valid, core_interrupt_acknowledge, cnt} = 5'h00;
    {sys_int_dest, sys_int_vector, sys_int_mode, sys_int_trig} = 20'h00000;
  end
  // bridge: takes a message write, slow mode accepts one cycle in four
  always @(posedge clk) begin
    cnt <= cnt + 2'h1;
    msg_ready <= !slow || cnt == 2'h3;
    sys_int_valid <= msg_valid && msg_ready;
    if (msg_valid && msg_ready) begin
      {sys_int_dest, sys_int_vector} <= {msg_addr[19:12], msg_data[7:0]};
      {sys_int_trig, sys_int_mode} <= {msg_data[15], msg_data[10:8]};
    end else begin
      {sys_int_dest, sys_int_vector} <= ~{sys_int_dest, sys_int_vector}; // stale lines toggle
      {sys_int_trig, sys_int_mode} <= ~{sys_int_trig, sys_int_mode};
    end
  end
  // core: one acknowledge pulse per raised request
  always @(posedge clk)
    core_interrupt_acknowledge <= ack_en && core_interrupt_request
                                  && !core_interrupt_acknowledge;
endmodule

//--- bench/imd_chk.sv
// port checker for the interrupt message delivery block
`timescale 1ns/1ps
module imd_chk (
  input wire        clk,
  input wire        nrst,
  input wire [8:0]  avs_address,
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_readdata,
  input wire        avs_waitrequest,
  input wire        msg_valid,
  input wire [31:0] msg_addr,
  input wire [31:0] msg_data,
  input wire        msg_ready,
  input wire        core_interrupt_request,
  input wire        core_interrupt_acknowledge,
  input wire [7:0]  core_vector,
  input wire        irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // steps of the bus, message and core exchanges
  sequence s_bus_start;
    (avs_read || avs_write) && avs_waitrequest && !(avs_write && avs_address[8]);
  endsequence
  sequence s_offer;
    msg_valid && !msg_ready;
  endsequence
  sequence s_ack;
    core_interrupt_acknowledge && core_interrupt_request;
  endsequence
  a_bus_answer: assert property (s_bus_start |=> !avs_waitrequest)
    else $error("register access not answered after one wait state");
  a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_write_rdata: assert property (avs_write && !avs_waitrequest |-> avs_readdata == 32'h0)
    else $error("read data not zero on a write");
  a_top_vector: assert property (avs_read && !avs_waitrequest && avs_address == 9'h002
    |-> avs_readdata[31:8] == 24'h0 && (avs_readdata[7:0] >= 8'h10 || avs_readdata[7:0] == 8'h0f))
    else $error("top vector read out of range");
  a_msg_hold: assert property (s_offer |=> msg_valid && $stable(msg_addr) && $stable(msg_data))
    else $error("message changed before it was taken");
  a_msg_shape: assert property (msg_valid |-> msg_addr[31:20] == 12'hf00
    && msg_addr[11:0] == 12'h0 && msg_data[31:16] == 16'h0 && msg_data[14:11] == 4'h0)
    else $error("message format wrong");
  a_ack_drop: assert property (s_ack |=> !core_interrupt_request)
    else $error("request stayed high after acknowledge");
  a_ack_vector: assert property (s_ack |=> core_vector >= 8'h10)
    else $error("core vector below the first usable vector");
  a_reset_idle: assert property (disable iff (1'b0) !nrst |=> !msg_valid
    && !core_interrupt_request && !irq && avs_waitrequest)
    else $error("outputs not idle after reset");
endmodule

bind imd_top imd_chk u_chk (.*);

//--- bench/testbench.sv
// self-checking bench for the interrupt message delivery block
`timescale 1ns/1ps
module testbench;
  reg         clk, nrst, slow, ack_en, avs_read, avs_write;
  reg  [8:0]  avs_address;
  reg  [31:0] avs_writedata, rnd, cap_addr, cap_data, q, e;
  reg  [3:0]  io_pin, avs_byteenable;
  reg  [4:0]  src;
  reg  [7:0]  id, v, w;
  integer     failures, n_checks, n_msg, n0, i, k;
  wire [31:0] avs_readdata, msg_addr, msg_data;
  wire [7:0]  sys_int_dest, sys_int_vector, core_vector;
  wire [2:0]  sys_int_mode;
  wire        avs_waitrequest, msg_valid, msg_ready, sys_int_valid, sys_int_trig, irq;
  wire        core_interrupt_request, core_interrupt_acknowledge, local_interrupt_pin_a;
  wire        local_interrupt_pin_b, interval_timer_event, perf_monitor_event;
  wire        corrected_machine_check;
  // local sources from one vector
  assign {local_interrupt_pin_b, local_interrupt_pin_a} = src[4:3];
  assign {corrected_machine_check, perf_monitor_event, interval_timer_event} = src[2:0];
  imd_top dut (.*);
  imd_far far (.*);
  // clock and capture of each message taken by the bridge
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk)
    if (msg_valid === 1'b1 && msg_ready === 1'b1) begin
      cap_addr <= msg_addr;
      cap_data <= msg_data;
      n_msg <= n_msg + 1;
    end
  function [31:0] xs(input [31:0] x);
    begin
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      xs = x ^ (x << 5);
    end
  endfunction
  task nv;
    begin
      rnd = xs(rnd);
      v = 8'h10 + rnd[7:0] % 8'hf0;
    end
  endtask
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("Error %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  // one register access, held until waitrequest is sampled low
  task bus(input wr, input [8:0] a, input [31:0] d);
    integer t;
    begin
      t = 0;
      @(posedge clk);
      avs_read <= !wr;
      avs_write <= wr;
      avs_address <= a;
      avs_writedata <= d;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0 && t < 100) begin
        @(posedge clk);
        t = t + 1;
      end
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (t == 100) failures = failures + 1;
    end
  endtask
  task rdc(input string nm, input [8:0] a, input [31:0] x);
    begin
      bus(1'b0, a, 32'h0);
      chk(nm, q, x);
    end
  endtask
  // read the top vector, then end its service
  task take(input [7:0] x);
    begin
      rdc("top vector", 9'h002, {24'h0, x});
      if (x != 8'h0f) bus(1'b1, 9'h003, 32'h0);
    end
  endtask
  task wmsg(input integer c);
    integer t;
    begin
      t = 0;
      while (n_msg - n0 < c && t < 200) begin
        @(posedge clk);
        t = t + 1;
      end
      if (t == 200) failures = failures + 1;
      repeat (3) @(posedge clk);
    end
  endtask
  task pulse(input [8:0] m, input integer n);
    begin
      @(posedge clk);
      {src, io_pin} <= m;
      repeat (n) @(posedge clk);
      {src, io_pin} <= 9'h000;
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  initial begin
    #(25 * 30000);
    failures = failures + 1;
    give_verdict;
  end
  initial begin
    {nrst, slow, ack_en, avs_read, avs_write, io_pin, src} = 14'h0000;
    {avs_address, avs_writedata} = 41'h0;
    avs_byteenable = 4'hf;
    {failures, n_checks, n_msg, rnd} = {32'h0, 32'h0, 32'h0, 32'h8};
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    // reset contents, read-only and unmapped places
    for (i = 0; i < 4; i = i + 1)
      rdc("entry reset", 9'h020 + i[8:0], 32'h0001_0000);
    bus(1'b1, 9'h008, 32'hffff_ffff);
    rdc("pending ro", 9'h008, 32'h0);
    rdc("unmapped", 9'h006, 32'h0);
    $display("test reset done");
    // one entry per pin; last pin aimed at another receiver
    rnd = xs(rnd);
    id = rnd[15:8];
    bus(1'b1, 9'h000, {24'h0, id});
    avs_byteenable <= 4'he;
    bus(1'b1, 9'h000, {24'h0, ~id});
    avs_byteenable <= 4'hf;
    rdc("id lanes", 9'h000, {24'h0, id});
    for (i = 0; i < 4; i = i + 1) begin
      nv;
      w = (i == 3) ? ~id : id;
      e = {w, 13'h0, i[2:0], v};
      slow <= i[0];
      bus(1'b1, 9'h020 + i[8:0], e);
      rdc("entry", 9'h020 + i[8:0], e);
      n0 = n_msg;
      pulse(9'h001 << i, 4);
      wmsg(1);
      chk("msg addr", cap_addr, {12'hf00, w, 12'h000});
      chk("msg data", cap_data, {16'h0, e[15:0]});
      take(i == 3 ? 8'h0f : v);
    end
    $display("test pins done");
    // two edges merge into one pending vector
    nv;
    bus(1'b1, 9'h020, {id, 16'h0, v});
    bus(1'b1, 9'h004, 32'h7);
    n0 = n_msg;
    pulse(9'h001, 4);
    repeat (4) @(posedge clk);
    pulse(9'h001, 4);
    wmsg(2);
    chk("edge msgs", n_msg - n0, 2);
    rdc("pending", {6'h01, v[7:5]}, 32'h1 << v[4:0]);
    rdc("status", 9'h004, 32'h7);
    take(v);
    rdc("pending", {6'h01, v[7:5]}, 32'h0);
    take(8'h0f);
    // level pin: one message per assertion
    nv;
    bus(1'b1, 9'h021, {id, 8'h00, 8'h80, v});
    n0 = n_msg;
    pulse(9'h002, 40);
    wmsg(1);
    chk("level msgs", n_msg - n0, 1);
    chk("msg data", cap_data, {16'h0080, v});
    take(v);
    $display("test merge done");
    // processor stores: self, other target, vector too low
    for (k = 0; k < 3; k = k + 1) begin
      nv;
      if (k == 2) v = 8'h05;
      w = (k == 1) ? id + 8'h1 : id;
      rnd = xs(rnd);
      n0 = n_msg;
      bus(1'b1, {1'b1, w}, {rnd[31:11], k[2:0], v});
      wmsg(1);
      chk("store addr", cap_addr, {12'hf00, w, 12'h000});
      chk("store data", cap_data, {21'h0, k[2:0], v});
      take(k == 0 ? v : 8'h0f);
    end
    $display("test store done");
    // local sources stay local; masked entry ignored
    for (k = 0; k < 5; k = k + 1) begin
      nv;
      bus(1'b1, 9'h010 + k[8:0], {24'h0, v});
      n0 = n_msg;
      pulse(9'h010 << k, k < 3 ? 1 : 4);
      repeat (6) @(posedge clk);
      chk("no message", n_msg - n0, 0);
      take(v);
    end
    bus(1'b1, 9'h010, {15'h0, 1'b1, 8'h0, v});
    pulse(9'h010, 1);
    repeat (6) @(posedge clk);
    take(8'h0f);
    // priority class mask, nesting and end of service
    bus(1'b1, 9'h010, 32'h10);
    bus(1'b1, 9'h011, 32'hff);
    pulse(9'h030, 1);
    repeat (6) @(posedge clk);
    bus(1'b1, 9'h001, 32'hf);
    take(8'h0f);
    bus(1'b1, 9'h001, 32'h0);
    rdc("top vector", 9'h002, 32'hff);
    take(8'h0f);
    bus(1'b1, 9'h003, 32'h0);
    take(8'h10);
    $display("test local done");
    // core handshake and interrupt line
    bus(1'b1, 9'h005, 32'h1);
    bus(1'b1, 9'h004, 32'h7);
    ack_en <= 1'b1;
    nv;
    n0 = n_msg;
    bus(1'b1, {1'b1, id}, {24'h0, v});
    wmsg(1);
    repeat (6) @(posedge clk);
    chk("core vector", {24'h0, core_vector}, {24'h0, v});
    chk("irq set", {31'h0, irq}, 32'h1);
    take(8'h0f);
    bus(1'b1, 9'h003, 32'h0);
    bus(1'b1, 9'h004, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq clear", {31'h0, irq}, 32'h0);
    $display("test core done");
    give_verdict;
  end
endmodule
